// >>> dpll_reference_status_interrupts.sv
`timescale 1ns/1ns
// Operation
// - two-bit forced mode: 00 automatic, 01 normal, 10 holdover, 11 freerun
// - status word: bits 6-4 ref frequency, 3-2 ref index, 1-0 mode
// - interrupt flag bit 3 sets whenever lock status changes
// - interrupt flag bit 2 sets whenever selected reference changes
// - flag bit 1 sets on entering and on leaving holdover or MTIE
// - flag register bits 15 to 4 read as zero
// - interrupt output active while any flag set with its mask low
// - writing one to a clear bit resets that flag only
// - mask bit 3 high blocks lock change interrupt
// - mask bit 2 high blocks reference change interrupt
// - mask bit 1 high blocks holdover entry or exit interrupt
// - per-reference failure flags, four bits each, ref 3 at top
// - multi-period lower mask high forces that check to pass
// - multi-period upper mask high forces that check to pass
// - single-period lower mask high forces that check to pass
// - single-period upper mask high forces that check to pass
module dpll_reference_status_interrupts
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [dpll_status_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dpll_status_pkg::DATA_W-1:0] i_wdata,
    input wire logic [1:0] i_forced_timing_mode,
    input wire logic [1:0] i_timing_mode_state,
    input wire logic [1:0] i_selected_ref_index,
    input wire logic [2:0] i_selected_ref_frequency,
    input wire logic i_lock_flag,
    input wire logic i_slew_limited_flag,
    input wire logic [15:0] i_check_fail_raw,
    output logic [dpll_status_pkg::DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    output logic [1:0] o_timing_mode,
    output logic [15:0] o_check_pass,
    output logic o_irq_n
);
    import dpll_status_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wire logic [15:0] irq_flags;
    logic [15:0] irq_mask;
    logic [15:0] irq_clear;
    logic [15:0] check_mask;
    logic [15:0] fail_status;
    logic [15:0] ref_status;
    logic [1:0] prev_mode;
    logic [1:0] prev_index;
    logic prev_lock;
    logic history_valid;
    logic [2:0] history_fill;
    logic [15:0] next_rdata;
    wire logic [15:0] next_flags;
    wire logic [15:0] masked_fail;
    logic [15:0] clear_bits;
    logic [1:0] next_timing_mode;
    logic lock_event;
    logic ref_event;
    logic holdover_event;
    logic was_holdover;
    logic is_holdover;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = i_cs && i_wr;
    assign rd_hit = i_cs && i_rd;

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    // automatic lets the reference state machine pick; otherwise forced
    always_comb
    begin
        case (i_forced_timing_mode)
            FORCE_NORMAL: next_timing_mode = MODE_NORMAL;
            FORCE_HOLDOVER: next_timing_mode = MODE_HOLDOVER;
            FORCE_FREERUN: next_timing_mode = MODE_FREERUN;
            default: next_timing_mode = i_timing_mode_state;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            o_timing_mode <= MODE_FREERUN;
        else
            o_timing_mode <= next_timing_mode;
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ref_status <= 16'h0000;
        end
        else
        begin
            ref_status <= 16'h0000;
            ref_status[SLEW_LIMITED_BIT] <= i_slew_limited_flag;
            ref_status[LOCK_BIT] <= i_lock_flag;
            ref_status[REF_FREQ_LSB +: 3] <= i_selected_ref_frequency;
            ref_status[REF_INDEX_LSB +: 2] <= i_selected_ref_index;
            ref_status[MODE_LSB +: 2] <= o_timing_mode;
        end
    end

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // the mode field needs three edges after reset to reach prev_mode;
    // comparing earlier would turn reset values into a false event
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            prev_mode <= 2'h0;
            prev_index <= 2'h0;
            prev_lock <= 1'b0;
            history_fill <= 3'h0;
        end
        else
        begin
            prev_mode <= ref_status[MODE_LSB +: 2];
            prev_index <= ref_status[REF_INDEX_LSB +: 2];
            prev_lock <= ref_status[LOCK_BIT];
            history_fill <= {history_fill[1:0], 1'b1};
        end
    end

    assign history_valid = history_fill[2];

    assign is_holdover = (ref_status[MODE_LSB +: 2] == MODE_HOLDOVER)
        || (ref_status[MODE_LSB +: 2] == MODE_MTIE);
    assign was_holdover = (prev_mode == MODE_HOLDOVER) || (prev_mode == MODE_MTIE);
    assign lock_event = history_valid && (prev_lock != ref_status[LOCK_BIT]);
    assign ref_event = history_valid
        && (prev_index != ref_status[REF_INDEX_LSB +: 2]);
    assign holdover_event = history_valid && (was_holdover != is_holdover);

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    assign clear_bits = (wr_hit && i_addr == REG_DPLL_INTERRUPT_CLEAR)
        ? (i_wdata & IRQ_FIELD) : 16'h0000;

    event_flag_cell u_lock_change
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_set(lock_event),
        .i_clear(clear_bits[LOCK_CHANGE_BIT]),
        .o_flag(irq_flags[LOCK_CHANGE_BIT]),
        .o_next(next_flags[LOCK_CHANGE_BIT])
    );

    event_flag_cell u_ref_change
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_set(ref_event),
        .i_clear(clear_bits[REF_CHANGE_BIT]),
        .o_flag(irq_flags[REF_CHANGE_BIT]),
        .o_next(next_flags[REF_CHANGE_BIT])
    );

    event_flag_cell u_holdover_change
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_set(holdover_event),
        .i_clear(clear_bits[HOLDOVER_CHANGE_BIT]),
        .o_flag(irq_flags[HOLDOVER_CHANGE_BIT]),
        .o_next(next_flags[HOLDOVER_CHANGE_BIT])
    );

    // unused flag positions never hold anything
    assign irq_flags[15:4] = 12'h000;
    assign irq_flags[0] = 1'b0;
    assign next_flags[15:4] = 12'h000;
    assign next_flags[0] = 1'b0;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            o_irq_n <= 1'b1;
        else
            o_irq_n <= ~|(next_flags & ~irq_mask & IRQ_FIELD);
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            irq_mask <= RST_INTERRUPT_MASK;
        else if (wr_hit && i_addr == REG_DPLL_INTERRUPT_MASK)
            irq_mask <= (i_wdata & IRQ_FIELD) | FIXED_ONE;
    end

    // the written value is kept for read back; clearing acts in the write cycle only
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            irq_clear <= RST_INTERRUPT_CLEAR;
        else if (wr_hit && i_addr == REG_DPLL_INTERRUPT_CLEAR)
            irq_clear <= (i_wdata & IRQ_FIELD) | FIXED_ONE;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            check_mask <= RST_CHECK_MASK;
        else if (wr_hit && i_addr == REG_REFERENCE_CHECK_MASK)
            check_mask <= i_wdata;
    end

    // ----------------------------------------------------------------
    // reference limit checks
    // ----------------------------------------------------------------
    // one nibble of checks per reference, reference 3 at the top
    for (genvar r = 0; r < NUM_REFS; r++)
    begin : g_ref
        check_mask_cell
        #(
            .WIDTH(CHECKS_PER_REF)
        )
        u_cell
        (
            .i_fail(i_check_fail_raw[r*CHECKS_PER_REF +: CHECKS_PER_REF]),
            .i_mask(check_mask[r*CHECKS_PER_REF +: CHECKS_PER_REF]),
            .o_fail(masked_fail[r*CHECKS_PER_REF +: CHECKS_PER_REF])
        );
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            fail_status <= 16'h0000;
            o_check_pass <= 16'hffff;
        end
        else
        begin
            fail_status <= masked_fail;
            o_check_pass <= ~masked_fail;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped addresses read zero
    always_comb
    begin
        if (i_addr == REG_REFERENCE_CHANGE_STATUS)
            next_rdata = ref_status;
        else if (i_addr == REG_DPLL_INTERRUPT_FLAGS)
            next_rdata = irq_flags & IRQ_FIELD;
        else if (i_addr == REG_DPLL_INTERRUPT_MASK)
            next_rdata = irq_mask;
        else if (i_addr == REG_DPLL_INTERRUPT_CLEAR)
            next_rdata = irq_clear;
        else if (i_addr == REG_REFERENCE_FAILURE_STATUS)
            next_rdata = fail_status;
        else if (i_addr == REG_REFERENCE_CHECK_MASK)
            next_rdata = check_mask;
        else
            next_rdata = 16'h0000;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 16'h0000;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= rd_hit;
            if (rd_hit)
                o_rdata <= next_rdata;
        end
    end

endmodule

// ----------------------------------------------------------------
// one sticky event flag
// ----------------------------------------------------------------
// a set in the clearing cycle wins, so an event is never lost
module event_flag_cell
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_flag,
    output logic o_next
);
    always_comb
    begin
        if (i_set)
            o_next = 1'b1;
        else if (i_clear)
            o_next = 1'b0;
        else
            o_next = o_flag;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            o_flag <= 1'b0;
        else
            o_flag <= o_next;
    end
endmodule

// ----------------------------------------------------------------
// limit check masking for one reference
// ----------------------------------------------------------------
// a masked check reads as passed, so its failure flag stays low
module check_mask_cell
#(
    parameter int WIDTH = 4
)
(
    input wire logic [WIDTH-1:0] i_fail,
    input wire logic [WIDTH-1:0] i_mask,
    output logic [WIDTH-1:0] o_fail
);
    import dpll_status_pkg::*;

    assign o_fail[CHK_MULTI_LOWER] = i_fail[CHK_MULTI_LOWER] && !i_mask[CHK_MULTI_LOWER];
    assign o_fail[CHK_MULTI_UPPER] = i_fail[CHK_MULTI_UPPER] && !i_mask[CHK_MULTI_UPPER];
    assign o_fail[CHK_SINGLE_LOWER] = i_fail[CHK_SINGLE_LOWER]
        && !i_mask[CHK_SINGLE_LOWER];
    assign o_fail[CHK_SINGLE_UPPER] = i_fail[CHK_SINGLE_UPPER]
        && !i_mask[CHK_SINGLE_UPPER];
endmodule

// >>> dpll_status_pkg.sv
package dpll_status_pkg;

    // ----------------------------------------------------------------
    // host register port geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    // ----------------------------------------------------------------
    // register offsets (word addresses of the host port)
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_REFERENCE_CHANGE_STATUS = 12'h04c;
    localparam logic [11:0] REG_DPLL_INTERRUPT_FLAGS = 12'h066;
    localparam logic [11:0] REG_DPLL_INTERRUPT_MASK = 12'h067;
    localparam logic [11:0] REG_DPLL_INTERRUPT_CLEAR = 12'h068;
    localparam logic [11:0] REG_REFERENCE_FAILURE_STATUS = 12'h069;
    localparam logic [11:0] REG_REFERENCE_CHECK_MASK = 12'h06a;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_INTERRUPT_MASK = 16'h000f;
    localparam logic [15:0] RST_INTERRUPT_CLEAR = 16'h0000;
    localparam logic [15:0] RST_CHECK_MASK = 16'h0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SLEW_LIMITED_BIT = 8;
    localparam int LOCK_BIT = 7;
    localparam int REF_FREQ_LSB = 4;
    localparam int REF_INDEX_LSB = 2;
    localparam int MODE_LSB = 0;
    localparam int LOCK_CHANGE_BIT = 3;
    localparam int REF_CHANGE_BIT = 2;
    localparam int HOLDOVER_CHANGE_BIT = 1;
    localparam int NUM_REFS = 4;
    localparam int CHECKS_PER_REF = 4;
    // order of the four checks inside one reference nibble
    localparam int CHK_MULTI_LOWER = 3;
    localparam int CHK_MULTI_UPPER = 2;
    localparam int CHK_SINGLE_LOWER = 1;
    localparam int CHK_SINGLE_UPPER = 0;

    // mask and flag field span used by the interrupt logic
    localparam logic [15:0] IRQ_FIELD = 16'h000e;
    // bit 0 of the mask register always reads one; bit 0 of the clear register resets to zero and reads one once written
    localparam logic [15:0] FIXED_ONE = 16'h0001;

    // ----------------------------------------------------------------
    // mode encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] FORCE_AUTOMATIC = 2'h0;
    localparam logic [1:0] FORCE_NORMAL = 2'h1;
    localparam logic [1:0] FORCE_HOLDOVER = 2'h2;
    localparam logic [1:0] FORCE_FREERUN = 2'h3;

    typedef enum logic [1:0]
    {
        MODE_MTIE,
        MODE_NORMAL,
        MODE_HOLDOVER,
        MODE_FREERUN
    } timing_mode_t;

endpackage

// >>> dpll_reference_status_interrupts_sva.sv
`timescale 1ns/1ns
module dpll_reference_status_interrupts_sva
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [dpll_status_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dpll_status_pkg::DATA_W-1:0] i_wdata,
    input wire logic [1:0] i_forced_timing_mode,
    input wire logic [1:0] i_timing_mode_state,
    input wire logic [1:0] i_selected_ref_index,
    input wire logic i_lock_flag,
    input wire logic [15:0] i_check_fail_raw,
    input wire logic [dpll_status_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [1:0] o_timing_mode,
    input wire logic [15:0] o_check_pass,
    input wire logic o_irq_n
);
    import dpll_status_pkg::*;
    // ----
    // host port, status and interrupt relations
    // ----
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_rvalid_one_pulse: assert property (o_rvalid == $past(i_cs && i_rd))
        else $error("read answer pulse wrong");
    a_flags_reserved_zero: assert property (o_rvalid && $past(i_addr) == REG_DPLL_INTERRUPT_FLAGS
        |-> (o_rdata & 16'hfff1) == 16'h0000) else $error("flag reserved bits set");
    a_status_upper_zero: assert property (o_rvalid && $past(i_addr) == REG_REFERENCE_CHANGE_STATUS
        |-> o_rdata[15:9] == 7'h00) else $error("status upper bits set");
    a_mode_select: assert property ($stable({i_forced_timing_mode, i_timing_mode_state}) [*5]
        |-> o_timing_mode == ((i_forced_timing_mode == FORCE_AUTOMATIC) ?
        i_timing_mode_state : i_forced_timing_mode)) else $error("timing mode wrong");
    a_pass_unfailed: assert property ((~o_check_pass & ~$past(i_check_fail_raw)) == 16'h0000)
        else $error("check failed without cause");
    a_reset_quiet: assert property ($rose(i_nrst) |-> o_irq_n && !o_rvalid
        && o_check_pass == 16'hffff && o_timing_mode == 2'h3) else $error("reset state wrong");
    a_mask_silences: assert property ((i_cs && i_wr && i_addr == REG_DPLL_INTERRUPT_MASK
        && i_wdata[3:1] == 3'h7) ##1 !(i_cs && i_wr && i_addr == REG_DPLL_INTERRUPT_MASK)
        |=> o_irq_n) else $error("masked interrupt active");
    a_clear_empties: assert property ($stable({i_lock_flag, i_selected_ref_index,
        i_forced_timing_mode, i_timing_mode_state}) [*6] ##0 (i_cs && i_wr
        && i_addr == REG_DPLL_INTERRUPT_CLEAR && i_wdata[3:1] == 3'h7) ##1 (i_cs && i_rd
        && i_addr == REG_DPLL_INTERRUPT_FLAGS) |=> o_rdata[3:1] == 3'h0)
        else $error("flags survive clear");
endmodule
bind dpll_reference_status_interrupts dpll_reference_status_interrupts_sva u_sva
(
    .i_clk, .i_nrst, .i_cs, .i_rd, .i_wr, .i_addr, .i_wdata, .i_forced_timing_mode,
    .i_timing_mode_state, .i_selected_ref_index, .i_lock_flag, .i_check_fail_raw,
    .o_rdata, .o_rvalid, .o_timing_mode, .o_check_pass, .o_irq_n
);

// >>> test_dpll_reference_status_interrupts.sv
`timescale 1ns/1ns
module test_dpll_reference_status_interrupts;
    import dpll_status_pkg::*;
    logic i_clk, i_nrst, i_cs, i_rd, i_wr, i_lock_flag, i_slew_limited_flag, o_rvalid, o_irq_n;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic [1:0] i_forced_timing_mode, i_timing_mode_state;
    logic [1:0] i_selected_ref_index, o_timing_mode;
    logic [2:0] i_selected_ref_frequency;
    logic [15:0] i_check_fail_raw, o_check_pass, raw, m;
    logic [31:0] r;
    logic [31:0] seed = 32'd48390;
    int err_total, cmp_count, k;
    dpll_reference_status_interrupts u_dut
    (
        .i_clk, .i_nrst, .i_cs, .i_rd, .i_wr, .i_addr, .i_wdata, .i_forced_timing_mode,
        .i_timing_mode_state, .i_selected_ref_index, .i_selected_ref_frequency,
        .i_lock_flag, .i_slew_limited_flag, .i_check_fail_raw, .o_rdata, .o_rvalid,
        .o_timing_mode, .o_check_pass, .o_irq_n
    );
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] stat_exp();
        logic [1:0] md;
        md = (i_forced_timing_mode == FORCE_AUTOMATIC) ? i_timing_mode_state : i_forced_timing_mode;
        return {7'h00, i_slew_limited_flag, i_lock_flag, i_selected_ref_frequency,
            i_selected_ref_index, md};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // request is held until the edge that takes it; no release so calls may run back to back
    task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
        i_cs <= 1'b1;
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        acc(1'b1, a, d);
        i_cs <= 1'b0;
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        i_cs <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_clk);
        chk((o_rvalid === 1'b1) ? o_rdata : ~exp, exp);
    endtask
    task automatic fire(input int e);
        case (e)
            3: i_lock_flag <= ~i_lock_flag;
            2: i_selected_ref_index <= i_selected_ref_index + 2'h1;
            default: i_forced_timing_mode <= i_forced_timing_mode ^ 2'h3;
        endcase
        wt(4);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial
    begin
        err_total = 0;
        cmp_count = 0;
        {i_nrst, i_cs, i_rd, i_wr, i_lock_flag, i_slew_limited_flag} <= 6'h00;
        {i_addr, i_wdata, i_check_fail_raw} <= 44'h0;
        {i_forced_timing_mode, i_timing_mode_state, i_selected_ref_index} <= 6'h00;
        i_selected_ref_frequency <= 3'h0;
        wt(20);
        i_nrst <= 1'b1;
        wt(1);
        rd(REG_DPLL_INTERRUPT_MASK, RST_INTERRUPT_MASK);
        rd(REG_REFERENCE_CHECK_MASK, RST_CHECK_MASK);
        rd(REG_DPLL_INTERRUPT_FLAGS, 16'h0000);
        rd(12'h123, 16'h0000);
        chk({15'h0, o_irq_n}, 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            i_forced_timing_mode <= i[1:0];
            {i_timing_mode_state, i_selected_ref_index} <= r[3:0];
            i_selected_ref_frequency <= r[6:4] % 3'h7;
            {i_lock_flag, i_slew_limited_flag} <= r[8:7];
            wt(4);
            rd(REG_REFERENCE_CHANGE_STATUS, stat_exp());
            chk({14'h0, o_timing_mode}, stat_exp() & 16'h0003);
        end
        $display("test status done");
        i_forced_timing_mode <= FORCE_NORMAL;
        wt(8);
        acc(1'b1, REG_DPLL_INTERRUPT_CLEAR, 16'h000e);
        rd(REG_DPLL_INTERRUPT_FLAGS, 16'h0000);
        wr(REG_DPLL_INTERRUPT_MASK, 16'h0000);
        rd(REG_DPLL_INTERRUPT_MASK, FIXED_ONE);
        // two rounds so the mode event is seen on entry and on exit
        for (int n = 0; n < 6; n++)
        begin
            k = 3 - (n % 3);
            fire(k);
            wr(REG_DPLL_INTERRUPT_FLAGS, 16'hffff);
            rd(REG_DPLL_INTERRUPT_FLAGS, 16'h1 << k);
            chk({15'h0, o_irq_n}, 16'h0000);
            wr(REG_DPLL_INTERRUPT_MASK, 16'h1 << k);
            wt(1);
            chk({15'h0, o_irq_n}, 16'h0001);
            wr(REG_DPLL_INTERRUPT_MASK, 16'h000e ^ (16'h1 << k));
            wt(1);
            chk({15'h0, o_irq_n}, 16'h0000);
            wr(REG_DPLL_INTERRUPT_MASK, 16'h000e);
            wr(REG_DPLL_INTERRUPT_CLEAR, 16'h1 << k);
            wr(REG_DPLL_INTERRUPT_MASK, 16'h0000);
            wt(1);
            chk({15'h0, o_irq_n}, 16'h0001);
        end
        fire(3);
        fire(2);
        wr(REG_DPLL_INTERRUPT_CLEAR, 16'h0008);
        rd(REG_DPLL_INTERRUPT_FLAGS, 16'h0004);
        rd(REG_DPLL_INTERRUPT_CLEAR, 16'h0009);
        $display("test interrupt done");
        for (int i = 0; i < 10; i++)
        begin
            r = rnd();
            raw = (i < 2) ? 16'hffff : r[15:0];
            m = (i < 2) ? {16{i[0]}} : r[31:16];
            wr(REG_REFERENCE_CHECK_MASK, m);
            i_check_fail_raw <= raw;
            wt(3);
            rd(REG_REFERENCE_CHECK_MASK, m);
            rd(REG_REFERENCE_FAILURE_STATUS, raw & ~m);
            chk(o_check_pass, ~(raw & ~m));
        end
        $display("test check mask done");
        give_verdict();
    end
    // the tests need well under a thousand cycles
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule
